// >>> hw/cpu_programmer_model_regs.v
// Notes on behaviour
// RULE1: seventeen 32-bit general registers, 32-bit program counter, 16-bit status register.
// RULE2: data registers write at byte, word or long size.
// RULE3: address registers and both stack pointers serve as stacks and bases.
// RULE4: any of the seventeen registers may be picked as index register.
// RULE5: supervisor flag set selects supervisor stack pointer for all stack accesses; index selection bypasses this, index 15 is always the user stack.
// RULE6: supervisor flag clear selects user stack; supervisor stack is write protected.
// RULE7: low status byte holds overflow, zero, negative, carry, extend flags.
// RULE8: three-bit mask; interrupt taken only when level exceeds mask or is seven.
// RULE9: level seven interrupts are always taken.
// RULE10: high status byte also holds trace and supervisor flags only.
// RULE11: small variant drives 20 address lines, large variant 22.
// RULE12: separate 8-bit data bus and address lines, no multiplexing.
// RULE13: indirect forms plain, postincrement, predecrement, displacement, indexed; update base.
// RULE14: 16-bit displacement forms; indexed forms use 8-bit displacement plus index.
// RULE15: immediate operands full or quick form encoding one to eight.
// RULE16: absolute short 16-bit and long 32-bit addresses.
// RULE17: operands: bits, 4-bit decimal digits, bytes, words, long words.
// RULE18: flags low bits, mask bits ten to eight, supervisor 13, trace 15.
`timescale 1ns/1ns
`default_nettype none
`include "prog_model_consts.vh"

module cpu_programmer_model_regs
(
  input  wire        clk,
  input  wire        srst,
  input  wire        large_pkg,
  input  wire        wr_en,
  input  wire [4:0]  wr_sel,
  input  wire [1:0]  wr_size,
  input  wire [31:0] wr_data,
  input  wire [4:0]  rd_sel,
  input  wire [4:0]  index_sel,
  input  wire        index_long,
  input  wire        pc_wr,
  input  wire [31:0] pc_data,
  input  wire        sr_wr,
  input  wire        sr_ccr_only,
  input  wire [15:0] sr_data,
  input  wire        flags_wr,
  input  wire [4:0]  flags_data,
  input  wire [2:0]  irq_level,
  input  wire        ea_go,
  input  wire [2:0]  ea_mode,
  input  wire [2:0]  ea_reg,
  input  wire [15:0] ext_word,
  input  wire        abs_long,
  input  wire [31:0] abs_val,
  input  wire [1:0]  op_size,
  input  wire        imm_quick,
  input  wire [2:0]  quick_code,
  input  wire [31:0] imm_full,
  input  wire [4:0]  bit_num,
  input  wire [1:0]  bcd_digit,
  input  wire [7:0]  bus_data_in,
  output reg  [31:0] rd_data_ff,
  output reg  [31:0] pc_ff,
  output reg  [15:0] status_register_ff,
  output reg  [31:0] active_stack_ptr_ff,
  output reg         irq_accept_ff,
  output reg  [31:0] ea_addr_ff,
  output reg  [21:0] addr_bus_ff,
  output reg  [7:0]  data_bus_out_ff,
  output reg  [31:0] imm_value_ff,
  output reg         bit_value_ff,
  output reg  [3:0]  bcd_value_ff,
  output reg         priv_viol_ff
);

  // -----------------------------------------------------------------
  // register storage
  // -----------------------------------------------------------------
  // 0..7 data_regs, 8..14 address_regs, 15 user_stack_ptr,
  // 16 supervisor_stack_ptr
  reg [31:0] gen_regs_ff [0:16]; // RULE1

  wire       super_mode = status_register_ff[`SR_SUPER_BIT];

  // map architectural number to physical slot; 15 is the active stack
  function [4:0] phys_num;
    input [4:0] sel;
    input       sup;
    begin
      if (sel == `STACK_REG_NUM)
        phys_num = sup ? `ALT_STACK_NUM : `STACK_REG_NUM; // RULE5
      else
        phys_num = sel;
    end
  endfunction

  wire [4:0] wr_phys  = phys_num(wr_sel, super_mode);
  wire [4:0] rd_phys  = phys_num(rd_sel, super_mode);
  wire [4:0] idx_phys = (index_sel > `ALT_STACK_NUM) ? `ALT_STACK_NUM : index_sel;
  wire [4:0] ea_phys  = phys_num({2'h1, ea_reg}, super_mode);

  // the supervisor copy can be written directly only in supervisor state
  wire       wr_blocked = (wr_sel == `ALT_STACK_NUM) && !super_mode; // RULE6

  // -----------------------------------------------------------------
  // effective address unit
  // -----------------------------------------------------------------
  wire [31:0] ea_addr;
  wire [31:0] base_upd;
  wire        base_wr;
  wire        ea_is_stack = (ea_reg == 3'h7);

  ea_calc ea_calc_inst
  (
    .ea_mode    (ea_mode),
    .base_val   (gen_regs_ff[ea_phys]), // RULE3
    .pc_val     (pc_ff),
    .index_val  (gen_regs_ff[idx_phys]), // RULE4
    .index_long (index_long),
    .ext_word   (ext_word),
    .abs_long   (abs_long),
    .abs_val    (abs_val),
    .op_size    (op_size),
    .stack_reg  (ea_is_stack),
    .ea_addr    (ea_addr),
    .base_upd   (base_upd),
    .base_wr    (base_wr)
  );

  // -----------------------------------------------------------------
  // sized write merge
  // -----------------------------------------------------------------
  reg [31:0] merged;

  always @*
  begin
    merged = gen_regs_ff[wr_phys];
    if (wr_sel < 5'h08)
    begin
      case (wr_size)
        `SIZE_BYTE: merged = {merged[31:8], wr_data[7:0]}; // RULE2
        `SIZE_WORD: merged = {merged[31:16], wr_data[15:0]}; // RULE2
        default:    merged = wr_data; // RULE2
      endcase
    end
    else
    begin
      // word writes to address registers sign extend
      if (wr_size == `SIZE_WORD)
        merged = {{16{wr_data[15]}}, wr_data[15:0]}; // RULE3
      else
        merged = wr_data;
    end
  end

  // -----------------------------------------------------------------
  // register file update
  // -----------------------------------------------------------------
  // explicit write wins over the address update on the same register
  genvar g;
  generate
    for (g = 0; g < 17; g = g + 1)
    begin : g_reg
      always @(posedge clk)
      begin
        if (srst)
          gen_regs_ff[g] <= `REG_RESET_VAL;
        else if (wr_en && !wr_blocked && wr_phys == g)
          gen_regs_ff[g] <= merged;
        else if (ea_go && base_wr && ea_phys == g)
          gen_regs_ff[g] <= base_upd; // RULE13
      end
    end
  endgenerate

  // -----------------------------------------------------------------
  // program counter and status register
  // -----------------------------------------------------------------
  always @(posedge clk)
  begin
    if (srst)
      pc_ff <= `PC_RESET_VAL;
    else if (pc_wr)
      pc_ff <= pc_data; // RULE1
  end

  reg [15:0] nxt_sr;

  always @*
  begin
    nxt_sr = status_register_ff;
    if (sr_wr)
    begin
      // user state may only touch the condition byte
      if (sr_ccr_only || !super_mode)
        nxt_sr = {status_register_ff[15:8], sr_data[7:0]};
      else
        nxt_sr = sr_data;
    end
    if (flags_wr)
      nxt_sr[`SR_EXTEND_BIT:`SR_CARRY_BIT] = flags_data; // RULE7
    nxt_sr = nxt_sr & `SR_DEFINED_MASK; // RULE10 RULE18
  end

  always @(posedge clk)
  begin
    if (srst)
      status_register_ff <= `SR_RESET_VAL;
    else
      status_register_ff <= nxt_sr;
  end

  always @(posedge clk)
  begin
    if (srst)
      priv_viol_ff <= 1'b0;
    else
      priv_viol_ff <= (sr_wr && !sr_ccr_only && !super_mode) || (wr_en && wr_blocked); // RULE6
  end

  // -----------------------------------------------------------------
  // interrupt priority
  // -----------------------------------------------------------------
  wire [2:0] mask_lvl = status_register_ff[`SR_MASK_HI:`SR_MASK_LO];

  always @(posedge clk)
  begin
    if (srst)
      irq_accept_ff <= 1'b0;
    else
      irq_accept_ff <= (irq_level > mask_lvl) || (irq_level == 3'h7); // RULE8 RULE9
  end

  // -----------------------------------------------------------------
  // read ports and addressing
  // -----------------------------------------------------------------
  always @(posedge clk)
  begin
    if (srst)
    begin
      rd_data_ff          <= 32'h00000000;
      active_stack_ptr_ff <= 32'h00000000;
      ea_addr_ff          <= 32'h00000000;
      addr_bus_ff         <= 22'h000000;
      data_bus_out_ff     <= 8'h00;
    end
    else
    begin
      rd_data_ff          <= gen_regs_ff[rd_phys];
      active_stack_ptr_ff <= gen_regs_ff[phys_num(`STACK_REG_NUM, super_mode)]; // RULE5 RULE6
      if (ea_go)
      begin
        ea_addr_ff <= ea_addr;
        // small variant keeps the two top lines low
        addr_bus_ff <= large_pkg ? ea_addr[21:0] : {2'h0, ea_addr[19:0]}; // RULE11
      end
      data_bus_out_ff <= gen_regs_ff[rd_phys][7:0]; // RULE12
    end
  end

  // -----------------------------------------------------------------
  // operand forms
  // -----------------------------------------------------------------
  wire [31:0] operand = gen_regs_ff[rd_phys];

  always @(posedge clk)
  begin
    if (srst)
    begin
      imm_value_ff <= 32'h00000000;
      bit_value_ff <= 1'b0;
      bcd_value_ff <= 4'h0;
    end
    else
    begin
      // quick code zero encodes eight
      if (imm_quick)
        imm_value_ff <= (quick_code == 3'h0) ? 32'h00000008 : {29'h0, quick_code}; // RULE15
      else
        imm_value_ff <= imm_full; // RULE15
      bit_value_ff <= operand[bit_num]; // RULE17
      case (bcd_digit)
        2'h0:    bcd_value_ff <= operand[3:0]; // RULE17
        2'h1:    bcd_value_ff <= operand[7:4];
        2'h2:    bcd_value_ff <= bus_data_in[3:0];
        default: bcd_value_ff <= bus_data_in[7:4];
      endcase
    end
  end

endmodule // cpu_programmer_model_regs
`default_nettype wire

// >>> hw/ea_calc.v
`timescale 1ns/1ns
`default_nettype none
`include "prog_model_consts.vh"

module ea_calc
(
  input  wire [2:0]  ea_mode,
  input  wire [31:0] base_val,
  input  wire [31:0] pc_val,
  input  wire [31:0] index_val,
  input  wire        index_long,
  input  wire [15:0] ext_word,
  input  wire        abs_long,
  input  wire [31:0] abs_val,
  input  wire [1:0]  op_size,
  input  wire        stack_reg,
  output reg  [31:0] ea_addr,
  output reg  [31:0] base_upd,
  output reg         base_wr
);

  reg [31:0] step;
  reg [31:0] idx;
  reg [31:0] d8;
  reg [31:0] d16;

  always @*
  begin
    // byte steps on the stack keep it word aligned
    case (op_size)
      `SIZE_BYTE: step = stack_reg ? 32'h00000002 : 32'h00000001;
      `SIZE_WORD: step = 32'h00000002;
      default:    step = 32'h00000004;
    endcase
    idx = index_long ? index_val : {{16{index_val[15]}}, index_val[15:0]};
    d8  = {{24{ext_word[7]}}, ext_word[7:0]};
    d16 = {{16{ext_word[15]}}, ext_word};
    base_upd = base_val;
    base_wr  = 1'b0;
    case (ea_mode)
      `EA_INDIRECT:  ea_addr = base_val; // RULE13
      `EA_POSTINC:
      begin
        ea_addr  = base_val;
        base_upd = base_val + step;
        base_wr  = 1'b1; // RULE13
      end
      `EA_PREDEC:
      begin
        ea_addr  = base_val - step;
        base_upd = base_val - step;
        base_wr  = 1'b1; // RULE13
      end
      `EA_DISP16:    ea_addr = base_val + d16; // RULE14
      `EA_INDEX8:    ea_addr = base_val + d8 + idx; // RULE14
      `EA_PC_DISP16: ea_addr = pc_val + d16; // RULE14
      `EA_PC_INDEX8: ea_addr = pc_val + d8 + idx; // RULE14
      `EA_ABSOLUTE:  ea_addr = abs_long ? abs_val : d16; // RULE16
      default:       ea_addr = base_val;
    endcase
  end

endmodule // ea_calc
`default_nettype wire

// >>> hw/prog_model_consts.vh
`ifndef PROG_MODEL_CONSTS_VH
`define PROG_MODEL_CONSTS_VH
// status register field positions
`define SR_CARRY_BIT      0
`define SR_OVERFLOW_BIT   1
`define SR_ZERO_BIT       2
`define SR_NEGATIVE_BIT   3
`define SR_EXTEND_BIT     4
`define SR_MASK_LO        8
`define SR_MASK_HI        10
`define SR_SUPER_BIT      13
`define SR_TRACE_BIT      15
// defined bits of the status register, others read zero
`define SR_DEFINED_MASK   16'hA71F
// reset values: supervisor state, mask at level seven
`define SR_RESET_VAL      16'h2700
`define PC_RESET_VAL      32'h00000000
`define REG_RESET_VAL     32'h00000000
// operand sizes
`define SIZE_BYTE         2'h0
`define SIZE_WORD         2'h1
`define SIZE_LONG         2'h2
// addressing forms for the effective address unit
`define EA_INDIRECT       3'h0
`define EA_POSTINC        3'h1
`define EA_PREDEC         3'h2
`define EA_DISP16         3'h3
`define EA_INDEX8         3'h4
`define EA_PC_DISP16      3'h5
`define EA_PC_INDEX8      3'h6
`define EA_ABSOLUTE       3'h7
// index register numbering: 0..7 data, 8..15 address, 16 supervisor stack
`define STACK_REG_NUM     5'h0F
`define ALT_STACK_NUM     5'h10
// external address widths per package
`define ADDR_W_SMALL      20
`define ADDR_W_LARGE      22
`define DATA_BUS_W        8
`endif

// >>> tb/cpu_programmer_model_regs_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module cpu_programmer_model_regs_monitor
(
  input wire logic        clk,
  input wire logic        srst,
  input wire logic        large_pkg,
  input wire logic        wr_en,
  input wire logic [4:0]  wr_sel,
  input wire logic        sr_wr,
  input wire logic        sr_ccr_only,
  input wire logic        flags_wr,
  input wire logic [4:0]  flags_data,
  input wire logic [2:0]  irq_level,
  input wire logic        ea_go,
  input wire logic        imm_quick,
  input wire logic [2:0]  quick_code,
  input wire logic [15:0] status_register_ff,
  input wire logic        irq_accept_ff,
  input wire logic [31:0] ea_addr_ff,
  input wire logic [21:0] addr_bus_ff,
  input wire logic [31:0] imm_value_ff,
  input wire logic        priv_viol_ff
);
  // ----------
  // properties
  // ----------
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  wire logic user_st = !status_register_ff[13];
  wire logic bad_req = user_st && ((sr_wr && !sr_ccr_only) || (wr_en && wr_sel == 5'h10));
  chk_sr_undef_zero:
    assert property ((status_register_ff & 16'h58E0) == 16'h0000)
    else $error("undefined status bit set");
  // mask may move with an sr write, so only judged when it stood still
  chk_irq_mask_cmp:
    assert property (!sr_wr && !$past(sr_wr) |=> irq_accept_ff == ($past(irq_level) == 3'h7
      || $past(irq_level) > $past(status_register_ff[10:8])))
    else $error("interrupt acceptance wrong");
  chk_irq_level_seven:
    assert property (irq_level == 3'h7 |=> irq_accept_ff)
    else $error("level seven not accepted");
  chk_user_sr_block:
    assert property (user_st && sr_wr && !sr_ccr_only |=> $stable(status_register_ff[15:8]))
    else $error("user state changed system byte");
  chk_ssp_guard:
    assert property (user_st && wr_en && wr_sel == 5'h10 |=> priv_viol_ff)
    else $error("protected stack write not flagged");
  chk_viol_cause:
    assert property (priv_viol_ff |-> $past(bad_req))
    else $error("violation pulse without cause");
  chk_flags_win:
    assert property (flags_wr |=> status_register_ff[4:0] == $past(flags_data))
    else $error("flag write lost");
  chk_addr_small:
    assert property (ea_go && !large_pkg |=> addr_bus_ff == {2'h0, ea_addr_ff[19:0]})
    else $error("small package address lines wrong");
  chk_quick_imm:
    assert property (imm_quick |=> imm_value_ff ==
      ($past(quick_code) == 3'h0 ? 32'h8 : {29'h0, $past(quick_code)}))
    else $error("quick immediate wrong");
endmodule // cpu_programmer_model_regs_monitor
bind cpu_programmer_model_regs cpu_programmer_model_regs_monitor cpu_programmer_model_regs_monitor_inst (.*);
`default_nettype wire

// >>> tb/cpu_programmer_model_regs_test.sv
`timescale 1ns/1ns
`default_nettype none
module cpu_programmer_model_regs_test;
  logic        clk = 1'b0, srst = 1'b1, large_pkg = 1'b0, wr_en = 1'b0, index_long = 1'b0;
  logic        pc_wr = 1'b0, sr_wr = 1'b0, sr_ccr_only = 1'b0, flags_wr = 1'b0, ea_go = 1'b0;
  logic        abs_long = 1'b0, imm_quick = 1'b0, bit_value_ff, irq_accept_ff, priv_viol_ff;
  logic [1:0]  wr_size = 2'h0, op_size = 2'h0, bcd_digit = 2'h0;
  logic [2:0]  irq_level = 3'h0, ea_mode = 3'h0, ea_reg = 3'h0, quick_code = 3'h0, st;
  logic [3:0]  bcd_value_ff;
  logic [4:0]  wr_sel = 5'h00, rd_sel = 5'h00, index_sel = 5'h00, flags_data = 5'h00;
  logic [4:0]  bit_num = 5'h00;
  logic [7:0]  bus_data_in = 8'h00, data_bus_out_ff;
  logic [15:0] sr_data = 16'h0000, ext_word = 16'h0000, status_register_ff;
  logic [21:0] addr_bus_ff;
  logic [31:0] wr_data = 32'h0, pc_data = 32'h0, abs_val = 32'h0, imm_full = 32'h0;
  logic [31:0] rd_data_ff, pc_ff, active_stack_ptr_ff, ea_addr_ff, imm_value_ff, a, b, x, e, p, ix;
  int          mismatches = 0, samples_checked = 0, viol_seen = 0, v0;

  cpu_programmer_model_regs cpu_programmer_model_regs_inst (.*);

  always #4 clk = ~clk;
  always @(posedge clk)
    if (priv_viol_ff === 1'b1)
      viol_seen <= viol_seen + 1;

  // --------------
  // helpers
  // --------------
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task summarize;
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // two extra edges after the write edge: one for the registered read, one spare
  task wr(input logic [4:0] s, input logic [1:0] z, input logic [31:0] d);
    @(posedge clk);
    wr_en <= 1'b1;
    wr_sel <= s;
    wr_size <= z;
    wr_data <= d;
    rd_sel <= s;
    @(posedge clk);
    wr_en <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task srw(input logic c, input logic [15:0] d, input logic f, input logic [4:0] fd);
    @(posedge clk);
    sr_wr <= 1'b1;
    sr_ccr_only <= c;
    sr_data <= d;
    flags_wr <= f;
    flags_data <= fd;
    @(posedge clk);
    sr_wr <= 1'b0;
    flags_wr <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask
  function automatic logic [31:0] sx(input logic [15:0] w);
    return {{16{w[15]}}, w};
  endfunction
  function automatic logic [31:0] ea_exp(input logic [2:0] md, input logic [15:0] w);
    case (md)
      3'h0, 3'h1: return a;
      3'h2: return a - st;
      3'h3: return a + sx(w);
      3'h4: return a + sx({{8{w[7]}}, w[7:0]}) + ix;
      3'h5: return p + sx(w);
      3'h6: return p + sx({{8{w[7]}}, w[7:0]}) + ix;
      default: return abs_long ? abs_val : sx(w);
    endcase
  endfunction

  // --------------
  // tests
  // --------------
  initial
  begin
    #200000;
    mismatches++;
    summarize;
  end
  initial
  begin
    x = $urandom(32'hB39B);
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    #1;
    chk(status_register_ff, 32'h2700);
    $display("reset test done");
    for (int i = 0; i < 8; i++)
    begin
      a = $urandom;
      b = $urandom;
      wr(i[4:0], 2'h2, a);
      chk(rd_data_ff, a);
      wr(i[4:0], 2'h0, b);
      chk(rd_data_ff, {a[31:8], b[7:0]});
      wr(i[4:0], 2'h1, b);
      chk(rd_data_ff, {a[31:16], b[15:0]});
      chk(data_bus_out_ff, b[7:0]);
      wr(5'h08 + i[4:0], 2'h1, b);
      chk(rd_data_ff, sx(b[15:0]));
    end
    $display("register size test done");
    for (int i = 0; i < 6; i++)
    begin
      x = $urandom | 32'h2000;
      srw(1'b0, x[15:0], i[0], x[20:16]);
      e = x & 32'hA71F;
      if (i[0])
        e[4:0] = x[20:16];
      chk(status_register_ff, e);
      srw(1'b1, 16'h00FF, 1'b0, 5'h00);
      chk(status_register_ff, {e[15:8], 8'h1F});
    end
    $display("status test done");
    for (int m = 0; m < 8; m++)
    begin
      srw(1'b0, {5'h04, m[2:0], 8'h00}, 1'b0, 5'h00);
      for (int l = 0; l < 8; l++)
      begin
        @(posedge clk);
        irq_level <= l[2:0];
        repeat (2) @(posedge clk);
        #1;
        chk(irq_accept_ff, l == 7 || l > m);
      end
    end
    irq_level <= 3'h0;
    $display("interrupt mask test done");
    p = $urandom;
    @(posedge clk);
    pc_data <= p;
    pc_wr <= 1'b1;
    @(posedge clk);
    pc_wr <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk(pc_ff, p);
    for (int md = 0; md < 8; md++)
    begin
      a = $urandom;
      b = $urandom;
      x = $urandom;
      wr(5'h08, 2'h2, a);
      wr(5'h01, 2'h2, b);
      ix = x[16] ? a : b;
      ix = x[17] ? ix : sx(ix[15:0]);
      st = x[21] ? 3'h4 : x[20] ? 3'h2 : 3'h1;
      ea_go <= 1'b1;
      ea_mode <= md[2:0];
      ext_word <= x[15:0];
      index_sel <= x[16] ? 5'h08 : 5'h01;
      index_long <= x[17];
      abs_long <= x[18];
      abs_val <= b;
      large_pkg <= x[19];
      op_size <= x[21] ? 2'h2 : {1'b0, x[20]};
      rd_sel <= 5'h08;
      @(posedge clk);
      ea_go <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      e = ea_exp(md[2:0], x[15:0]);
      chk(ea_addr_ff, e);
      chk(addr_bus_ff, x[19] ? e[21:0] : {2'h0, e[19:0]});
      chk(rd_data_ff, md == 1 ? a + st : md == 2 ? a - st : a);
    end
    $display("address calc test done");
    for (int q = 0; q < 9; q++)
    begin
      a = $urandom;
      imm_quick <= q < 8;
      quick_code <= q[2:0];
      imm_full <= a;
      bcd_digit <= q[1:0];
      bus_data_in <= a[7:0];
      repeat (2) @(posedge clk);
      #1;
      chk(imm_value_ff, q == 8 ? a : q == 0 ? 32'h8 : q);
      if (q[1])
        chk(bcd_value_ff, q[0] ? a[7:4] : a[3:0]);
    end
    imm_quick <= 1'b0;
    // register nibbles and bits come from the selected operand register
    a = $urandom;
    wr(5'h02, 2'h2, a);
    for (int k = 0; k < 4; k++)
    begin
      x = $urandom;
      @(posedge clk);
      bit_num <= x[4:0];
      bcd_digit <= k[1:0];
      bus_data_in <= x[15:8];
      repeat (2) @(posedge clk);
      #1;
      e = k[1] ? ({24'h0, x[15:8]} >> (4 * k[0])) : (a >> (4 * k[0]));
      chk(bit_value_ff, a[x[4:0]]);
      chk(bcd_value_ff, e[3:0]);
    end
    $display("immediate test done");
    a = $urandom;
    b = $urandom;
    wr(5'h0F, 2'h2, a);
    chk(active_stack_ptr_ff, a);
    srw(1'b0, 16'h0000, 1'b0, 5'h00);
    chk(active_stack_ptr_ff, 32'h0);
    v0 = viol_seen;
    wr(5'h0F, 2'h2, b);
    chk(active_stack_ptr_ff, b);
    wr(5'h10, 2'h2, x);
    chk(rd_data_ff, a);
    srw(1'b0, 16'h2700, 1'b0, 5'h00);
    chk(status_register_ff, 32'h0);
    chk(viol_seen, v0 + 2);
    @(posedge clk);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    #1;
    chk(status_register_ff, 32'h2700);
    $display("stack banking test done");
    summarize;
  end
endmodule // cpu_programmer_model_regs_test
`default_nettype wire
